/* fieldbus_node_pkg.sv */
// Shared constants, types and register map of the fieldbus node configuration block.
package fieldbus_node_pkg;

    // Timing: the clock rate and the indicator blink half period.
    localparam int unsigned CLK_FREQ_KHZ      = 40000;
    localparam int unsigned BLINK_HALF_MS     = 500;
    localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_FREQ_KHZ;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_NODE_STATE = 8'h00;
    localparam logic [7:0] OFS_PEND_ADDR  = 8'h04;
    localparam logic [7:0] OFS_PEND_RATE  = 8'h08;
    localparam logic [7:0] OFS_TERM_RATE  = 8'h0c;
    localparam logic [7:0] OFS_COMMAND    = 8'h10;
    localparam logic [7:0] OFS_STORED     = 8'h14;
    localparam logic [7:0] OFS_ACTIVE     = 8'h18;
    localparam logic [7:0] OFS_STATUS     = 8'h1c;

    // Command register bit positions.
    localparam int unsigned CMD_SAVE_BIT    = 0;
    localparam int unsigned CMD_RESTART_BIT = 1;
    localparam int unsigned CMD_CLR_REJ_BIT = 2;

    // Value limits and encodings.
    localparam logic [7:0]  SWITCH_ADDR_MAX = 8'h3f;
    localparam logic [3:0]  DIGIT_MAX       = 4'h9;
    localparam logic [3:0]  RATE_SWITCH_MAX = 4'h2;
    localparam logic [1:0]  RATE_CODE_MAX   = 2'h2;
    localparam logic [1:0]  RATE_CODE_125K  = 2'h0;
    localparam logic [1:0]  RATE_CODE_250K  = 2'h1;
    localparam logic [1:0]  RATE_CODE_500K  = 2'h2;
    localparam logic [31:0] KBPS_125        = 32'h0000007d;
    localparam logic [31:0] KBPS_250        = 32'h000000fa;
    localparam logic [31:0] KBPS_500        = 32'h000001f4;

    // Values after reset.
    localparam logic [5:0]  STORED_ADDR_RST = 6'h3f;
    localparam logic [1:0]  STORED_RATE_RST = 2'h0;
    localparam logic [8:0]  NODE_STATE_RST  = 9'h000;

    typedef enum logic [2:0] {
        LED_OFF,
        LED_GREEN,
        LED_GREEN_BLINK,
        LED_RED_BLINK,
        LED_RED
    } led_mode_e;

    // Node condition reported by the protocol firmware, bit 0 is online.
    typedef struct packed {
        logic bus_off;
        logic dup_address;
        logic io_timeout;
        logic recoverable_fault;
        logic config_valid;
        logic master_allocated;
        logic conn_established;
        logic dup_check_done;
        logic online;
    } node_state_s;

    // Address and bit rate in use, with where each came from.
    typedef struct packed {
        logic       rate_from_switch;
        logic       addr_from_switch;
        logic [1:0] rate;
        logic [5:0] addr;
    } node_config_s;

endpackage

/* node_switch_decode.sv */
// Decodes the rotary switches, falling back to stored values when out of range.
`timescale 1ns/1ps
`default_nettype none
module node_switch_decode
(
    input  wire logic [3:0]                  address_tens_switch_i,
    input  wire logic [3:0]                  address_units_switch_i,
    input  wire logic [3:0]                  rate_switch_i,
    input  wire logic [5:0]                  stored_addr_i,
    input  wire logic [1:0]                  stored_rate_i,
    output fieldbus_node_pkg::node_config_s  config_o
);

    logic [7:0] sw_value;
    logic       addr_ok;
    logic       rate_ok;

    assign sw_value = ({4'h0, address_tens_switch_i} << 3)
                    + ({4'h0, address_tens_switch_i} << 1)
                    + {4'h0, address_units_switch_i};

    assign addr_ok = (address_units_switch_i <= fieldbus_node_pkg::DIGIT_MAX)
                   && (sw_value <= fieldbus_node_pkg::SWITCH_ADDR_MAX);
    assign rate_ok = (rate_switch_i <= fieldbus_node_pkg::RATE_SWITCH_MAX);

    always_comb
    begin
        config_o.addr_from_switch = addr_ok;
        config_o.rate_from_switch = rate_ok;
        config_o.addr = addr_ok ? sw_value[5:0] : stored_addr_i;
        config_o.rate = rate_ok ? rate_switch_i[1:0] : stored_rate_i;
    end

endmodule
`default_nettype wire

/* status_led_driver.sv */
// Drives the combined module and network indicator from the node condition.
`timescale 1ns/1ps
`default_nettype none
module status_led_driver
#(
    parameter int unsigned BLINK_HALF_CYCLES = fieldbus_node_pkg::BLINK_HALF_CYCLES
)
(
    input  wire logic                           ref_clk_i,
    input  wire logic                           rst_b_i,
    input  wire fieldbus_node_pkg::node_state_s state_i,
    output logic                                green_o,
    output logic                                red_o,
    output fieldbus_node_pkg::led_mode_e        mode_o
);

    localparam int unsigned CW = $clog2(BLINK_HALF_CYCLES + 1);

    logic [CW-1:0]                blink_count;
    logic                         blink_phase;
    fieldbus_node_pkg::led_mode_e next_mode;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            blink_count <= '0;
            blink_phase <= 1'b0;
        end
        else if (blink_count >= CW'(BLINK_HALF_CYCLES - 1))
        begin
            blink_count <= '0;
            blink_phase <= ~blink_phase;
        end
        else
        begin
            blink_count <= blink_count + CW'(1);
        end
    end

    // Faults that stop communication outrank the offline case, since a failed
    // duplicate check has completed and must still be visible.
    always_comb
    begin
        if (state_i.dup_address || state_i.bus_off)
            next_mode = fieldbus_node_pkg::LED_RED;
        else if (!state_i.online || !state_i.dup_check_done)
            next_mode = fieldbus_node_pkg::LED_OFF;
        else if (state_i.recoverable_fault || state_i.io_timeout)
            next_mode = fieldbus_node_pkg::LED_RED_BLINK;
        else if (state_i.conn_established && state_i.master_allocated
                 && state_i.config_valid)
            next_mode = fieldbus_node_pkg::LED_GREEN;
        else
            next_mode = fieldbus_node_pkg::LED_GREEN_BLINK;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mode_o  <= fieldbus_node_pkg::LED_OFF;
            green_o <= 1'b0;
            red_o   <= 1'b0;
        end
        else
        begin
            mode_o  <= next_mode;
            green_o <= (next_mode == fieldbus_node_pkg::LED_GREEN)
                    || ((next_mode == fieldbus_node_pkg::LED_GREEN_BLINK) && blink_phase);
            red_o   <= (next_mode == fieldbus_node_pkg::LED_RED)
                    || ((next_mode == fieldbus_node_pkg::LED_RED_BLINK) && blink_phase);
        end
    end

endmodule
`default_nettype wire

/* fieldbus_node_config_status.sv */
// Fieldbus node address, bit rate and status indicator logic with an AHB-Lite slave.
//
// Summary of operation
// - Address switches reading 0 to 63 give the station address directly.
// - Switches above 63 select the stored address from command or network object.
// - Address command, save, then full restart changes the stored station address.
// - Rate switch 0, 1, 2 selects 125, 250, 500 kbit/s.
// - Rate switch above 2 uses the stored rate code 0 to 2.
// - Terminal rate write accepts only 125, 250 or 500; stored after save and restart.
// - New address or rate applies only after save and restart.
// - Indicator off while offline or duplicate address check is unfinished; here duplicate address or bus-off still shows steady red.
// - Steady green when online, connected, configured and allocated to a master.
// - Blinking green when online but not connected, allocated or configured.
// - Blinking red on recoverable fault or timed-out I/O connection.
// - Steady red on duplicate address or bus-off.
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_node_config_status
#(
    parameter int unsigned BLINK_HALF_CYCLES = fieldbus_node_pkg::BLINK_HALF_CYCLES
)
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [3:0]  address_tens_switch_i,
    input  wire logic [3:0]  address_units_switch_i,
    input  wire logic [3:0]  rate_switch_i,
    output logic [5:0]       node_address_o,
    output logic [1:0]       bit_rate_code_o,
    output logic             node_restart_o,
    output logic             led_green_o,
    output logic             led_red_o
);

    // Bus data phase bookkeeping.
    logic                           wr_pending;
    logic [7:0]                     wr_offset;
    logic                           rd_take;

    // Software visible state.
    fieldbus_node_pkg::node_state_s node_state;
    logic [5:0]                     pend_addr;
    logic [1:0]                     pend_rate;
    logic [5:0]                     stored_addr;
    logic [1:0]                     stored_rate;
    logic                           rejected;
    logic                           resample;
    fieldbus_node_pkg::node_config_s active;

    // Decoded write strobes of the data phase.
    logic                           wr_state;
    logic                           wr_addr;
    logic                           wr_rate;
    logic                           wr_term;
    logic                           wr_cmd;
    logic                           do_save;
    logic                           do_restart;
    logic                           addr_bad;
    logic                           rate_bad;
    logic                           term_ok;
    logic [1:0]                     term_code;
    logic                           set_reject;

    fieldbus_node_pkg::node_config_s decoded;
    fieldbus_node_pkg::led_mode_e    led_mode;
    logic                            led_green;
    logic                            led_red;
    logic [31:0]                     next_rdata;

    assign rd_take = hsel && htrans[1] && hready && !hwrite;

    // The slave never stalls, so every transfer completes with one data phase.
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_pending <= 1'b0;
            wr_offset  <= 8'h00;
        end
        else if (hready)
        begin
            wr_pending <= hsel && htrans[1] && hwrite;
            wr_offset  <= {haddr[7:2], 2'b00};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb
    begin
        wr_state = 1'b0;
        wr_addr  = 1'b0;
        wr_rate  = 1'b0;
        wr_term  = 1'b0;
        wr_cmd   = 1'b0;
        if (!wr_pending)
            wr_state = 1'b0;
        else if (wr_offset == fieldbus_node_pkg::OFS_NODE_STATE)
            wr_state = 1'b1;
        else if (wr_offset == fieldbus_node_pkg::OFS_PEND_ADDR)
            wr_addr = 1'b1;
        else if (wr_offset == fieldbus_node_pkg::OFS_PEND_RATE)
            wr_rate = 1'b1;
        else if (wr_offset == fieldbus_node_pkg::OFS_TERM_RATE)
            wr_term = 1'b1;
        else if (wr_offset == fieldbus_node_pkg::OFS_COMMAND)
            wr_cmd = 1'b1;
    end

    assign do_save    = wr_cmd && hwdata[fieldbus_node_pkg::CMD_SAVE_BIT];
    assign do_restart = wr_cmd && hwdata[fieldbus_node_pkg::CMD_RESTART_BIT];
    assign addr_bad   = hwdata > {24'h000000, fieldbus_node_pkg::SWITCH_ADDR_MAX};
    assign rate_bad   = hwdata > {30'h00000000, fieldbus_node_pkg::RATE_CODE_MAX};

    always_comb
    begin
        term_ok   = 1'b1;
        term_code = fieldbus_node_pkg::RATE_CODE_125K;
        if (hwdata == fieldbus_node_pkg::KBPS_125)
            term_code = fieldbus_node_pkg::RATE_CODE_125K;
        else if (hwdata == fieldbus_node_pkg::KBPS_250)
            term_code = fieldbus_node_pkg::RATE_CODE_250K;
        else if (hwdata == fieldbus_node_pkg::KBPS_500)
            term_code = fieldbus_node_pkg::RATE_CODE_500K;
        else
            term_ok = 1'b0;
    end

    assign set_reject = (wr_addr && addr_bad) || (wr_rate && rate_bad)
                      || (wr_term && !term_ok);

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            node_state <= fieldbus_node_pkg::NODE_STATE_RST;
        else if (wr_state)
            node_state <= hwdata[8:0];
    end

    // Pending values are what the address and rate commands write; they do
    // nothing to the running node until saved and restarted.
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pend_addr <= fieldbus_node_pkg::STORED_ADDR_RST;
            pend_rate <= fieldbus_node_pkg::STORED_RATE_RST;
        end
        else
        begin
            if (wr_addr && !addr_bad)
                pend_addr <= hwdata[5:0];
            if (wr_rate && !rate_bad)
                pend_rate <= hwdata[1:0];
            else if (wr_term && term_ok)
                pend_rate <= term_code;
        end
    end

    // Stand-in for the non-volatile copy; it is lost on a hard reset here.
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stored_addr <= fieldbus_node_pkg::STORED_ADDR_RST;
            stored_rate <= fieldbus_node_pkg::STORED_RATE_RST;
        end
        else if (do_save)
        begin
            stored_addr <= pend_addr;
            stored_rate <= pend_rate;
        end
    end

    // The reject flag is sticky; a new reject wins over a clear in the same cycle.
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rejected <= 1'b0;
        else if (set_reject)
            rejected <= 1'b1;
        else if (wr_cmd && hwdata[fieldbus_node_pkg::CMD_CLR_REJ_BIT])
            rejected <= 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            resample <= 1'b1;
        else
            resample <= do_restart;
    end

    node_switch_decode u_switch_decode
    (
        .address_tens_switch_i  (address_tens_switch_i),
        .address_units_switch_i (address_units_switch_i),
        .rate_switch_i          (rate_switch_i),
        .stored_addr_i          (stored_addr),
        .stored_rate_i          (stored_rate),
        .config_o               (decoded)
    );

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            active          <= '0;
            node_address_o  <= 6'h00;
            bit_rate_code_o <= 2'h0;
            node_restart_o  <= 1'b0;
        end
        else
        begin
            node_restart_o <= resample;
            if (resample)
            begin
                active          <= decoded;
                node_address_o  <= decoded.addr;
                bit_rate_code_o <= decoded.rate;
            end
        end
    end

    status_led_driver
    #(
        .BLINK_HALF_CYCLES (BLINK_HALF_CYCLES)
    )
    u_led
    (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .state_i   (node_state),
        .green_o   (led_green),
        .red_o     (led_red),
        .mode_o    (led_mode)
    );

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            led_green_o <= 1'b0;
            led_red_o   <= 1'b0;
        end
        else
        begin
            led_green_o <= led_green;
            led_red_o   <= led_red;
        end
    end

    // Read data is prepared in the address phase so it leaves a flip-flop.
    always_comb
    begin
        next_rdata = 32'h00000000;
        if (haddr[7:0] == fieldbus_node_pkg::OFS_NODE_STATE)
            next_rdata = {23'h000000, node_state};
        else if (haddr[7:0] == fieldbus_node_pkg::OFS_PEND_ADDR)
            next_rdata = {26'h0000000, pend_addr};
        else if (haddr[7:0] == fieldbus_node_pkg::OFS_PEND_RATE)
            next_rdata = {30'h00000000, pend_rate};
        else if (haddr[7:0] == fieldbus_node_pkg::OFS_STORED)
            next_rdata = {22'h000000, stored_rate, 2'h0, stored_addr};
        else if (haddr[7:0] == fieldbus_node_pkg::OFS_ACTIVE)
            next_rdata = {22'h000000, active};
        else if (haddr[7:0] == fieldbus_node_pkg::OFS_STATUS)
            next_rdata = {16'h0000, rate_switch_i, address_tens_switch_i,
                          address_units_switch_i, led_mode, 1'b0};
        if (haddr[7:0] == fieldbus_node_pkg::OFS_STATUS)
            next_rdata[0] = rejected;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            hrdata <= 32'h00000000;
        else if (rd_take)
            hrdata <= next_rdata;
    end

endmodule
`default_nettype wire

/* node_checker_assertions.sv */
// Concurrent checks on the ports of the fieldbus node configuration block.
`timescale 1ns/1ps
`default_nettype none
module node_checker
#(
    parameter int unsigned BLINK_HALF_CYCLES = 8
)
(
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [3:0]  address_tens_switch_i,
    input wire logic [3:0]  address_units_switch_i,
    input wire logic [3:0]  rate_switch_i,
    input wire logic [5:0]  node_address_o,
    input wire logic [1:0]  bit_rate_code_o,
    input wire logic        node_restart_o,
    input wire logic        led_green_o,
    input wire logic        led_red_o
);
    logic [7:0] sw_val;

    // Worst case 15 * 10 + 15 still fits eight bits, so no wrap hides a bad digit.
    assign sw_val = {4'h0, address_tens_switch_i} * 8'h0a + {4'h0, address_units_switch_i};

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    ready_high_a: assert property ($past(rst_b_i) |-> hreadyout)
        else $error("slave inserted a wait state");
    rdata_hold_a: assert property (!$past(hsel && htrans[1] && !hwrite && hready)
        |-> $stable(hrdata))
        else $error("read data changed without a read");
    addr_hold_a: assert property (!node_restart_o |-> $stable(node_address_o))
        else $error("address changed without restart");
    rate_hold_a: assert property (!node_restart_o |-> $stable(bit_rate_code_o))
        else $error("bit rate changed without restart");
    restart_pulse_a: assert property (node_restart_o |=> !node_restart_o)
        else $error("restart pulse longer than one cycle");
    addr_switch_a: assert property (node_restart_o && $past(address_units_switch_i) <= 4'h9
        && $past(sw_val) <= 8'h3f |-> node_address_o == $past(sw_val[5:0]))
        else $error("switch address not applied");
    rate_switch_a: assert property (node_restart_o && $past(rate_switch_i) <= 4'h2
        |-> bit_rate_code_o == $past(rate_switch_i[1:0]))
        else $error("switch bit rate not applied");
    led_excl_a: assert property (!(led_green_o && led_red_o))
        else $error("both indicator colours lit");

    cover property (node_restart_o);
    cover property (led_green_o ##1 !led_green_o);
    cover property (led_red_o ##1 !led_red_o);
endmodule
bind fieldbus_node_config_status node_checker #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES))
    i_node_checker (.ref_clk_i, .rst_b_i, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .address_tens_switch_i, .address_units_switch_i, .rate_switch_i,
    .node_address_o, .bit_rate_code_o, .node_restart_o, .led_green_o, .led_red_o);
`default_nettype wire

/* net_master_model.sv */
// Network master model that joins the node at the address and rate it announces.
`timescale 1ns/1ps
`default_nettype none
module net_master_model
(
    input wire logic       ref_clk_i,
    input wire logic       rst_b_i,
    input wire logic [5:0] node_address_i,
    input wire logic [1:0] bit_rate_code_i,
    input wire logic       node_restart_i,
    output logic           joined_o,
    output logic [7:0]     joined_cfg_o
);
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            joined_o     <= 1'b0;
            joined_cfg_o <= 8'h00;
        end
        else
        begin
            joined_o <= node_restart_i;
            // Outside the join cycle the value churns, so nobody may rely on it.
            joined_cfg_o <= node_restart_i ? {bit_rate_code_i, node_address_i} : ~joined_cfg_o;
        end
    end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking testbench of the fieldbus node configuration block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk_i;
    logic        rst_b_i;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [3:0]  address_tens_switch_i;
    logic [3:0]  address_units_switch_i;
    logic [3:0]  rate_switch_i;
    logic [5:0]  node_address_o;
    logic [1:0]  bit_rate_code_o;
    logic        node_restart_o;
    logic        led_green_o;
    logic        led_red_o;
    logic        joined;
    logic [7:0]  joined_cfg;
    logic        rd_dp;
    logic [63:0] note;
    logic [31:0] seed;
    logic [5:0]  pa;
    logic [31:0] kb [3];
    logic [63:0] rq [$];
    logic [7:0]  cq [$];
    int          failures;
    int          num_checks;
    int          cycles;
    int          g_cnt;
    int          r_cnt;

    fieldbus_node_config_status #(.BLINK_HALF_CYCLES(8)) i_fieldbus_node_config_status (
        .ref_clk_i, .rst_b_i, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .address_tens_switch_i,
        .address_units_switch_i, .rate_switch_i, .node_address_o, .bit_rate_code_o,
        .node_restart_o, .led_green_o, .led_red_o);
    net_master_model i_net_master_model (.ref_clk_i, .rst_b_i,
        .node_address_i(node_address_o), .bit_rate_code_i(bit_rate_code_o),
        .node_restart_i(node_restart_o), .joined_o(joined), .joined_cfg_o(joined_cfg));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic end_sim;
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // A read notes its expectation once the address phase is accepted.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m);
        @(posedge ref_clk_i);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!w)
            rq.push_back({m, e});
        do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h00000000, e, m);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h00000000, 32'h00000000);
    endtask

    task automatic restart(input logic [31:0] cmd, input logic [7:0] e);
        cq.push_back(e);
        wr(fieldbus_node_pkg::OFS_COMMAND, cmd);
        repeat (4) @(posedge ref_clk_i);
    endtask

    task automatic sw(input logic [3:0] t, input logic [3:0] u, input logic [3:0] r,
                      input logic [7:0] e);
        @(posedge ref_clk_i);
        address_tens_switch_i  <= t;
        address_units_switch_i <= u;
        rate_switch_i          <= r;
        restart(32'h00000002, e);
    endtask

    // Any 32-cycle window of an eight-cycle half period holds exactly 16 lit cycles.
    task automatic led(input logic [8:0] st, input logic [2:0] md, input int g, input int r);
        wr(fieldbus_node_pkg::OFS_NODE_STATE, {23'h000000, st});
        repeat (4) @(posedge ref_clk_i);
        g_cnt = 0;
        r_cnt = 0;
        repeat (32)
        begin
            @(posedge ref_clk_i);
            g_cnt += (led_green_o === 1'b1) ? 1 : 0;
            r_cnt += (led_red_o === 1'b1) ? 1 : 0;
        end
        chk(g_cnt, g);
        chk(r_cnt, r);
        rd(fieldbus_node_pkg::OFS_STATUS, {28'h0000000, md, 1'b0}, 32'h0000000e);
    endtask

    initial
    begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i)
    begin
        if (rd_dp && rq.size() > 0)
        begin
            note = rq.pop_front();
            chk(hrdata & note[63:32], note[31:0]);
        end
        if (joined === 1'b1)
            chk({24'h000000, joined_cfg}, {24'h000000, (cq.size() > 0) ? cq.pop_front() : 8'hff});
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        {rst_b_i, hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
        {address_tens_switch_i, address_units_switch_i, rate_switch_i} = 12'h101;
        seed = 32'h04e2ba73;
        kb = '{fieldbus_node_pkg::KBPS_125, fieldbus_node_pkg::KBPS_250,
               fieldbus_node_pkg::KBPS_500};
        cq.push_back({2'h1, 6'h0a});
        repeat (6) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rd(fieldbus_node_pkg::OFS_STORED, 32'h0000003f, 32'h0000033f);
        rd(8'h20, 32'h00000000, 32'hffffffff);
        sw(4'h6, 4'h3, 4'h0, {2'h0, 6'h3f});
        sw(4'h0, 4'h0, 4'h1, {2'h1, 6'h00});
        sw(4'h4, 4'h2, 4'h2, {2'h2, 6'h2a});
        sw(4'h6, 4'h4, 4'h3, {2'h0, 6'h3f});
        for (int i = 0; i < 3; i++)
        begin
            wr(fieldbus_node_pkg::OFS_TERM_RATE, kb[i]);
            rd(fieldbus_node_pkg::OFS_PEND_RATE, i, 32'h00000003);
        end
        seed = lfsr(seed);
        pa = seed[5:0];
        wr(fieldbus_node_pkg::OFS_PEND_ADDR, {26'h0000000, pa});
        wr(fieldbus_node_pkg::OFS_TERM_RATE, fieldbus_node_pkg::KBPS_250);
        restart(32'h00000002, {2'h0, 6'h3f});
        wr(fieldbus_node_pkg::OFS_COMMAND, 32'h00000001);
        rd(fieldbus_node_pkg::OFS_STORED, {22'h0, 2'h1, 2'h0, pa}, 32'h0000033f);
        restart(32'h00000002, {2'h1, pa});
        wr(fieldbus_node_pkg::OFS_TERM_RATE, 32'h00000064);
        wr(fieldbus_node_pkg::OFS_PEND_RATE, 32'h00000003);
        rd(fieldbus_node_pkg::OFS_STATUS, 32'h00000001, 32'h00000001);
        rd(fieldbus_node_pkg::OFS_PEND_RATE, 32'h00000001, 32'h00000003);
        wr(fieldbus_node_pkg::OFS_COMMAND, 32'h00000004);
        rd(fieldbus_node_pkg::OFS_STATUS, 32'h00000000, 32'h00000001);
        wr(fieldbus_node_pkg::OFS_PEND_RATE, 32'h00000002);
        sw(4'h0, 4'hc, 4'hf, {2'h1, pa});
        restart(32'h00000003, {2'h2, pa});
        @(posedge ref_clk_i);
        {address_tens_switch_i, address_units_switch_i, rate_switch_i} <= 12'h151;
        repeat (8) @(posedge ref_clk_i);
        rd(fieldbus_node_pkg::OFS_ACTIVE, {22'h0, 2'h0, 2'h2, pa}, 32'h000003ff);
        led(9'h01e, 3'h0, 0, 0);
        led(9'h01f, 3'h1, 32, 0);
        led(9'h017, 3'h2, 16, 0);
        led(9'h05f, 3'h3, 0, 16);
        led(9'h03f, 3'h3, 0, 16);
        led(9'h09f, 3'h4, 0, 32);
        led(9'h100, 3'h4, 0, 32);
        cq.push_back({2'h1, 6'h0f});
        rst_b_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        chk(cq.size(), 0);
        chk(rq.size(), 0);
        end_sim();
    end
endmodule
`default_nettype wire
